// ==== shared/dukc_pkg.sv ====
// Shared constants and types for the update and keying control block
package dukc_pkg;

	// Host port widths
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int BANK_BYTES = 64;

	// Byte addresses of the register bank
	localparam logic [5:0] PHASE1_HI_ADDR = 6'h00;
	localparam logic [5:0] PHASE1_LO_ADDR = 6'h01;
	localparam logic [5:0] PHASE2_HI_ADDR = 6'h02;
	localparam logic [5:0] PHASE2_LO_ADDR = 6'h03;
	localparam logic [5:0] UPDATE_PERIOD_B3_ADDR = 6'h16;
	localparam logic [5:0] UPDATE_PERIOD_B2_ADDR = 6'h17;
	localparam logic [5:0] UPDATE_PERIOD_B1_ADDR = 6'h18;
	localparam logic [5:0] UPDATE_PERIOD_B0_ADDR = 6'h19;
	localparam logic [5:0] POWERDOWN_ADDR = 6'h1D;
	localparam logic [5:0] UPDATE_CTRL_ADDR = 6'h1F;
	localparam logic [5:0] KEYING_CTRL_ADDR = 6'h20;
	localparam logic [5:0] AMPLITUDE_SHAPE_HI_ADDR = 6'h21;
	localparam logic [5:0] AMPLITUDE_SHAPE_LO_ADDR = 6'h22;
	localparam logic [5:0] RAMP_RATE_ADDR = 6'h25;
	localparam logic [5:0] AUX_CONVERTER_HI_ADDR = 6'h26;
	localparam logic [5:0] AUX_CONVERTER_LO_ADDR = 6'h27;

	// Bit positions
	localparam int INTERNAL_UPDATE_BIT = 0;
	localparam int MAIN_POWERDOWN_BIT = 2;
	localparam int AUX_POWERDOWN_BIT = 1;
	localparam int MULT_ENABLE_BIT = 5;
	localparam int AUTO_RAMP_BIT = 4;

	// Reset values
	localparam logic [7:0] UPDATE_CTRL_RESET = 8'h01;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// Timing counts in system clock cycles
	localparam int SYS_CLK_HZ = 20000000;
	localparam logic [3:0] UPDATE_HIGH_CYCLES = 4'h8;
	localparam logic [31:0] UPDATE_PIN_MIN_PERIOD = 32'h0000_0005;
	localparam logic [7:0] RAMP_MIN_COUNT = 8'h03;

	// Amplitude limits
	localparam logic [11:0] AMP_FULL_SCALE = 12'hFFF;
	localparam logic [11:0] AMP_ZERO = 12'h000;

	// Host port bundle as seen at the pins
	typedef struct packed {
		logic wr_n;
		logic rd_n;
		logic [5:0] addr;
		logic [7:0] data;
	} dukc_port_s;

	localparam dukc_port_s PORT_IDLE = '{wr_n: 1'b1, rd_n: 1'b1, addr: 6'h00, data: 8'h00};

endpackage

// ==== hdl/dukc_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module dukc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dukc_sync_s;

	dukc_sync_s st_q;
	dukc_sync_s st_d;

	always_comb begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '{meta: RST_VAL, stable: RST_VAL};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;

endmodule

// ==== hdl/dukc_reload_cnt.sv ====
// Reloading down-counter emitting one pulse per pass through zero
`timescale 1ns/1ns
module dukc_reload_cnt #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic tick,
	input wire logic stall,
	input wire logic [W-1:0] load_val,
	// Result
	output logic pulse
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic pulse;
	} dukc_cnt_s;

	dukc_cnt_s st_q;
	dukc_cnt_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.pulse = 1'b0;
		if (!stall && tick) begin
			if (st_q.cnt == '0) begin
				st_d.cnt = load_val;
				st_d.pulse = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign pulse = st_q.pulse;

endmodule

// ==== hdl/dukc_top.sv ====
// Update clock, phase select and shaped keying control around the synthesizer core
//
// What this block does
// - Phase-select pin low applies first phase offset, high applies the second.
// - Buffered writes reach the active bank only on an internal update pulse or a rising external edge.
// - External update edges are synchronised to the system clock first.
// - Update source bit resets high (internal); low selects external pin input.
// - Internal interval comes from the 32-bit update period bytes; select in 1F.
// - Update counter decrements at half clock rate, updating each time it hits zero.
// - Internal updates are spaced (N+1) times two system clock periods.
// - Internal mode drives each update onto the pin high for eight cycles at periods of 5 and up.
// - Period below 5 keeps the update pin high while updates continue.
// - Multiplier enable low gives full scale; high scales the cosine path.
// - Auto-ramp high uses the internal ramp; low uses the shape value register.
// - An 8-bit ramp counter pulses at zero, stepping the 12-bit amplitude counter.
// - Factor zero gives zero, all ones near full scale, proportional between.
// - Ramp countdown value below 3 stalls the counter and holds the factor.
// - Amplitude steps are spaced by countdown value plus one clock periods.
// - Zero to full scale takes 4095 amplitude steps.
// - Keying pin high ramps up and holds full scale; low ramps down to zero.
// - Aux converter takes a 12-bit twos-complement value, refreshed every clock.
// - Main and aux power-down bits each power down their converter alone.
// - Host writes land in a buffer with no effect until an update.
`timescale 1ns/1ns
module dukc_top (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// Parallel host port
	input wire logic WR_N,
	input wire logic RD_N,
	input wire logic [5:0] ADDR,
	input wire logic [7:0] DATA_I,
	output logic [7:0] DATA_O,
	output logic DATA_OE,
	// Update strobe pin, two-way
	input wire logic UPDATE_STROBE_PIN_I,
	output logic UPDATE_STROBE_PIN_O,
	output logic UPDATE_STROBE_PIN_OE,
	// Modulation pins
	input wire logic PHASE_SELECT_PIN,
	input wire logic KEYING_PIN,
	// Cosine path
	input wire logic [11:0] COS_IN,
	output logic [11:0] COS_OUT,
	output logic [11:0] AMP_FACTOR,
	// Core and converter controls
	output logic [13:0] PHASE_OFFSET,
	output logic UPDATE_EVENT,
	output logic [11:0] AUX_CONVERTER_VALUE,
	output logic MAIN_CONVERTER_POWERDOWN,
	output logic AUX_CONVERTER_POWERDOWN
);

	typedef struct packed {
		logic [63:0][7:0] buf_bank;
		logic [63:0][7:0] act_bank;
		logic wr_n_prev;
		logic upd_prev;
		logic half;
		logic [3:0] high_cnt;
		logic upd_pin;
		logic update_evt;
		logic [11:0] amp;
		logic [11:0] factor;
		logic [11:0] cos_out;
		logic [13:0] phase;
		logic [11:0] aux_value;
		logic main_pd;
		logic aux_pd;
		logic [7:0] rd_data;
		logic rd_oe;
	} dukc_core_s;

	dukc_core_s st_q;
	dukc_core_s st_d;

	// Synchronised pins
	dukc_pkg::dukc_port_s port_s;
	logic upd_pin_s;
	logic phase_sel_s;
	logic key_s;

	// Active-bank fields
	logic internal_mode;
	logic mult_enable;
	logic auto_ramp;
	logic [31:0] update_period;
	logic [7:0] ramp_rate;
	logic [11:0] shape_value;

	// Counter pulses
	logic int_update_pulse;
	logic ramp_pulse;
	logic ext_rise;
	logic write_strobe;
	logic [24:0] product;
	logic [11:0] next_factor;

	dukc_sync #(
		.W(16),
		.RST_VAL(dukc_pkg::PORT_IDLE)
	) u_port_sync (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.async_in({WR_N, RD_N, ADDR, DATA_I}),
		.sync_out(port_s)
	);

	dukc_sync #(
		.W(3),
		.RST_VAL(3'h0)
	) u_pin_sync (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.async_in({UPDATE_STROBE_PIN_I, PHASE_SELECT_PIN, KEYING_PIN}),
		.sync_out({upd_pin_s, phase_sel_s, key_s})
	);

	// Fields decoded from the active bank only
	always_comb begin
		internal_mode = st_q.act_bank[dukc_pkg::UPDATE_CTRL_ADDR][dukc_pkg::INTERNAL_UPDATE_BIT];
		mult_enable = st_q.act_bank[dukc_pkg::KEYING_CTRL_ADDR][dukc_pkg::MULT_ENABLE_BIT];
		auto_ramp = st_q.act_bank[dukc_pkg::KEYING_CTRL_ADDR][dukc_pkg::AUTO_RAMP_BIT];
		update_period = {st_q.act_bank[dukc_pkg::UPDATE_PERIOD_B3_ADDR],
			st_q.act_bank[dukc_pkg::UPDATE_PERIOD_B2_ADDR],
			st_q.act_bank[dukc_pkg::UPDATE_PERIOD_B1_ADDR],
			st_q.act_bank[dukc_pkg::UPDATE_PERIOD_B0_ADDR]};
		ramp_rate = st_q.act_bank[dukc_pkg::RAMP_RATE_ADDR];
		shape_value = {st_q.act_bank[dukc_pkg::AMPLITUDE_SHAPE_HI_ADDR][3:0],
			st_q.act_bank[dukc_pkg::AMPLITUDE_SHAPE_LO_ADDR]};
	end

	// Internal update counter, ticking every second clock
	dukc_reload_cnt #(
		.W(32)
	) u_update_cnt (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.tick(st_q.half),
		.stall(1'b0),
		.load_val(update_period),
		.pulse(int_update_pulse)
	);

	// Ramp rate counter, ticking every clock
	dukc_reload_cnt #(
		.W(8)
	) u_ramp_cnt (
		.clk(SYS_CLK),
		.rst_n(RESETN),
		.tick(1'b1),
		.stall(ramp_rate < dukc_pkg::RAMP_MIN_COUNT),
		.load_val(ramp_rate),
		.pulse(ramp_pulse)
	);

	// External edge seen only after synchronisation
	assign ext_rise = !internal_mode && upd_pin_s && !st_q.upd_prev;
	assign write_strobe = port_s.wr_n && !st_q.wr_n_prev;
	assign product = $signed(COS_IN) * $signed({1'b0, st_q.factor});

	always_comb begin
		st_d = st_q;
		st_d.wr_n_prev = port_s.wr_n;
		st_d.upd_prev = upd_pin_s;
		st_d.half = !st_q.half;

		// Host writes go to the buffer only
		if (write_strobe) begin
			st_d.buf_bank[port_s.addr] = port_s.data;
		end

		// Readback of the buffer
		st_d.rd_oe = !port_s.rd_n;
		st_d.rd_data = st_q.buf_bank[port_s.addr];

		// Transfer on either update source
		st_d.update_evt = 1'b0;
		if ((internal_mode && int_update_pulse) || ext_rise) begin
			st_d.act_bank = st_q.buf_bank;
			st_d.update_evt = 1'b1;
		end

		// Update pin pulse stretch in internal mode
		if (internal_mode && int_update_pulse) begin
			st_d.high_cnt = dukc_pkg::UPDATE_HIGH_CYCLES;
		end else if (st_q.high_cnt != 4'h0) begin
			st_d.high_cnt = st_q.high_cnt - 4'h1;
		end
		if (update_period < dukc_pkg::UPDATE_PIN_MIN_PERIOD) begin
			st_d.upd_pin = 1'b1;
		end else begin
			st_d.upd_pin = (st_d.high_cnt != 4'h0);
		end

		// Saturating amplitude ramp
		if (ramp_pulse) begin
			if (key_s && st_q.amp != dukc_pkg::AMP_FULL_SCALE) begin
				st_d.amp = st_q.amp + 12'h001;
			end else if (!key_s && st_q.amp != dukc_pkg::AMP_ZERO) begin
				st_d.amp = st_q.amp - 12'h001;
			end
		end

		// Multiplier factor selection
		if (!mult_enable) begin
			next_factor = dukc_pkg::AMP_FULL_SCALE;
		end else if (auto_ramp) begin
			next_factor = st_q.amp;
		end else begin
			next_factor = shape_value;
		end
		st_d.factor = next_factor;

		// Scaled or bypassed cosine sample
		if (mult_enable) begin
			st_d.cos_out = product[23:12];
		end else begin
			st_d.cos_out = COS_IN;
		end

		// Phase offset by select pin
		if (phase_sel_s) begin
			st_d.phase = {st_q.act_bank[dukc_pkg::PHASE2_HI_ADDR][5:0],
				st_q.act_bank[dukc_pkg::PHASE2_LO_ADDR]};
		end else begin
			st_d.phase = {st_q.act_bank[dukc_pkg::PHASE1_HI_ADDR][5:0],
				st_q.act_bank[dukc_pkg::PHASE1_LO_ADDR]};
		end

		// Converter controls
		st_d.aux_value = {st_q.act_bank[dukc_pkg::AUX_CONVERTER_HI_ADDR][3:0],
			st_q.act_bank[dukc_pkg::AUX_CONVERTER_LO_ADDR]};
		st_d.main_pd = st_q.act_bank[dukc_pkg::POWERDOWN_ADDR][dukc_pkg::MAIN_POWERDOWN_BIT];
		st_d.aux_pd = st_q.act_bank[dukc_pkg::POWERDOWN_ADDR][dukc_pkg::AUX_POWERDOWN_BIT];
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			st_q <= '0;
			st_q.buf_bank[dukc_pkg::UPDATE_CTRL_ADDR] <= dukc_pkg::UPDATE_CTRL_RESET;
			st_q.act_bank[dukc_pkg::UPDATE_CTRL_ADDR] <= dukc_pkg::UPDATE_CTRL_RESET;
			st_q.wr_n_prev <= 1'b1;
			st_q.upd_pin <= 1'b1;
			st_q.factor <= dukc_pkg::AMP_FULL_SCALE;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs
	assign DATA_O = st_q.rd_data;
	assign DATA_OE = st_q.rd_oe;
	assign UPDATE_STROBE_PIN_O = st_q.upd_pin;
	assign UPDATE_STROBE_PIN_OE = internal_mode;
	assign COS_OUT = st_q.cos_out;
	assign AMP_FACTOR = st_q.factor;
	assign PHASE_OFFSET = st_q.phase;
	assign UPDATE_EVENT = st_q.update_evt;
	assign AUX_CONVERTER_VALUE = st_q.aux_value;
	assign MAIN_CONVERTER_POWERDOWN = st_q.main_pd;
	assign AUX_CONVERTER_POWERDOWN = st_q.aux_pd;

endmodule

// ==== verification/dukc_host.sv ====
// Host model driving the parallel programming port
`timescale 1ns/1ns
module dukc_host (
	// Clock and readback
	input wire logic clk,
	input wire logic [7:0] q,
	// Port pins
	output logic wr_n,
	output logic rd_n,
	output logic [5:0] addr,
	output logic [7:0] data
);
	initial begin
		wr_n = 1'b1;
		rd_n = 1'b1;
		addr = 6'h00;
		data = 8'h00;
	end
	// Strobe low 4 clocks, address and data held 4 past the rise
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		#5;
		addr = a;
		data = d;
		wr_n = 1'b0;
		repeat (4) @(posedge clk);
		#5 wr_n = 1'b1;
		repeat (4) @(posedge clk);
		#5 data = ~d;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		#5;
		addr = a;
		rd_n = 1'b0;
		repeat (6) @(posedge clk);
		#5 d = q;
		rd_n = 1'b1;
	endtask
endmodule

// ==== verification/dukc_checker.sv ====
// Assertions on update, pin and keying outputs
`timescale 1ns/1ns
module dukc_checker (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// Watched outputs
	input wire logic [11:0] COS_OUT,
	input wire logic [11:0] AMP_FACTOR,
	input wire logic UPDATE_STROBE_PIN_O,
	input wire logic UPDATE_STROBE_PIN_OE,
	input wire logic UPDATE_EVENT,
	input wire logic [11:0] AUX_CONVERTER_VALUE,
	input wire logic MAIN_CONVERTER_POWERDOWN,
	input wire logic AUX_CONVERTER_POWERDOWN
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESETN);
	property p_evt;
		UPDATE_EVENT |=> !UPDATE_EVENT;
	endproperty
	a_evt: assert property (p_evt) else $error("long event");
	property p_pin;
		UPDATE_EVENT && UPDATE_STROBE_PIN_OE |-> UPDATE_STROBE_PIN_O;
	endproperty
	a_pin: assert property (p_pin) else $error("pin low at update");
	property p_high;
		$rose(UPDATE_STROBE_PIN_O) && UPDATE_STROBE_PIN_OE
		|-> (UPDATE_STROBE_PIN_O || !UPDATE_STROBE_PIN_OE)[*8];
	endproperty
	a_high: assert property (p_high) else $error("pin pulse short");
	property p_low;
		$fell(UPDATE_STROBE_PIN_O) && UPDATE_STROBE_PIN_OE
		|-> (!UPDATE_STROBE_PIN_O || !UPDATE_STROBE_PIN_OE)[*4];
	endproperty
	a_low: assert property (p_low) else $error("pin gap short");
	property p_zero;
		(AMP_FACTOR == 12'h000)[*3] |-> COS_OUT == 12'h000;
	endproperty
	a_zero: assert property (p_zero) else $error("zero factor output");
	property p_step;
		$changed(AMP_FACTOR) && !$past(UPDATE_EVENT) && !$past(UPDATE_EVENT, 2)
		|-> {1'b0, AMP_FACTOR} == {1'b0, $past(AMP_FACTOR)} + 13'h0001
		|| {1'b0, $past(AMP_FACTOR)} == {1'b0, AMP_FACTOR} + 13'h0001;
	endproperty
	a_step: assert property (p_step) else $error("bad factor step");
	property p_gap;
		$changed(AMP_FACTOR) && !$past(UPDATE_EVENT) && !$past(UPDATE_EVENT, 2)
		|=> ($stable(AMP_FACTOR) || $past(UPDATE_EVENT) || $past(UPDATE_EVENT, 2))[*3];
	endproperty
	a_gap: assert property (p_gap) else $error("steps too close");
	property p_held;
		$changed({AUX_CONVERTER_VALUE, MAIN_CONVERTER_POWERDOWN, AUX_CONVERTER_POWERDOWN})
		|-> $past(UPDATE_EVENT) || $past(UPDATE_EVENT, 2);
	endproperty
	a_held: assert property (p_held) else $error("change without update");
	c_ext: cover property (UPDATE_EVENT && !UPDATE_STROBE_PIN_OE);
	c_full: cover property (AMP_FACTOR == 12'hFFF && $past(AMP_FACTOR) == 12'hFFE);
	c_fall: cover property ($fell(UPDATE_STROBE_PIN_O));
endmodule
bind dukc_top dukc_checker i_dukc_checker (.SYS_CLK, .RESETN, .COS_OUT, .AMP_FACTOR,
	.UPDATE_STROBE_PIN_O, .UPDATE_STROBE_PIN_OE, .UPDATE_EVENT, .AUX_CONVERTER_VALUE,
	.MAIN_CONVERTER_POWERDOWN, .AUX_CONVERTER_POWERDOWN);

// ==== verification/tb.sv ====
// Self-checking bench for the update and keying block
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0, rst_n = 1'b0, upd = 1'b0, psel = 1'b0, key = 1'b0;
	logic wr_n, rd_n, oe, po, poe, evt, mpd, apd;
	logic [5:0] addr;
	logic [7:0] din, dout, r;
	logic [11:0] cos = 12'h000, cout, amp, aux;
	logic [13:0] ph;
	logic [41:0] exp_q[$], w, g;
	int miscompares = 0, cmp_count = 0, cyc = 0, t, h, n;
	wire pin = poe ? po : upd;
	dukc_top i_dukc_top (.SYS_CLK(clk), .RESETN(rst_n), .WR_N(wr_n), .RD_N(rd_n),
		.ADDR(addr), .DATA_I(din), .DATA_O(dout), .DATA_OE(oe), .UPDATE_STROBE_PIN_I(pin),
		.UPDATE_STROBE_PIN_O(po), .UPDATE_STROBE_PIN_OE(poe), .PHASE_SELECT_PIN(psel),
		.KEYING_PIN(key), .COS_IN(cos), .COS_OUT(cout), .AMP_FACTOR(amp), .PHASE_OFFSET(ph),
		.UPDATE_EVENT(evt), .AUX_CONVERTER_VALUE(aux), .MAIN_CONVERTER_POWERDOWN(mpd),
		.AUX_CONVERTER_POWERDOWN(apd));
	dukc_host i_dukc_host (.clk(clk), .q(dout), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
		.data(din));
	task automatic chk(input logic [41:0] got, want);
		cmp_count++;
		if (got !== want) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#5;
	endtask
	// Cycles to next update, counting pin-high cycles
	task automatic step;
		t = 0;
		h = 0;
		do begin
			tick(1);
			t++;
			h += po;
		end while (evt !== 1'b1 && t < 500);
	endtask
	task automatic pulse;
		tick(1);
		upd = 1'b1;
		tick(4);
		upd = 1'b0;
		tick(8);
	endtask
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			finish_test();
		end
	end
	always @(posedge clk) begin
		logic [41:0] m;
		#5;
		if (evt === 1'b1 && exp_q.size() > 0) begin
			m = exp_q.pop_front();
			tick(2);
			chk({ph, aux, mpd, apd}, {psel ? m[27:14] : m[41:28], m[13:0]});
		end
	end
	initial begin
		void'($urandom(32'hFE86));
		tick(12);
		rst_n = 1'b1;
		chk({poe, amp}, 13'h1FFF);
		n = 5 + $urandom % 12;
		i_dukc_host.wr(6'h19, n[7:0]);
		repeat (3) step();
		chk(t, 2 * (n + 1));
		chk(h, 8);
		i_dukc_host.wr(6'h19, 8'h04);
		repeat (3) step();
		chk(t, 10);
		chk(h, 10);
		i_dukc_host.wr(6'h1F, 8'h00);
		step();
		tick(3);
		chk(poe, 1'b0);
		$display("update timer test done");
		for (int i = 0; i < 3; i++) begin
			w = 42'({$urandom, $urandom});
			g = {ph, aux, mpd, apd};
			i_dukc_host.wr(6'h00, {2'b00, w[41:36]});
			i_dukc_host.wr(6'h01, w[35:28]);
			i_dukc_host.wr(6'h02, {2'b00, w[27:22]});
			i_dukc_host.wr(6'h03, w[21:14]);
			i_dukc_host.wr(6'h26, {4'h0, w[13:10]});
			i_dukc_host.wr(6'h27, w[9:2]);
			i_dukc_host.wr(6'h1D, {5'h00, w[1:0], 1'b0});
			chk({ph, aux, mpd, apd}, g);
			psel = w[20];
			exp_q.push_back(w);
			pulse();
			psel = ~psel;
			tick(6);
			chk(ph, psel ? w[27:14] : w[41:28]);
		end
		$display("external update test done");
		i_dukc_host.wr(6'h25, 8'h03);
		i_dukc_host.wr(6'h20, 8'h30);
		pulse();
		cos = 12'($urandom);
		tick(4);
		chk({amp, cout}, 24'h0);
		key = 1'b1;
		tick(20);
		for (int i = 0; i < 2; i++) begin
			g[11:0] = amp;
			t = 0;
			do begin
				tick(1);
				t++;
			end while (amp === g[11:0] && t < 50);
		end
		chk(t, 4);
		chk(amp, g[11:0] + 12'h001);
		t = 0;
		while (amp !== 12'hFFF && t < 17000) begin
			tick(1);
			t++;
		end
		chk(amp, 12'hFFF);
		tick(40);
		chk(amp, 12'hFFF);
		n = ($signed(cos) * 4095) >>> 12;
		chk(cout, n[11:0]);
		$display("ramp test done");
		i_dukc_host.wr(6'h25, 8'h02);
		pulse();
		key = 1'b0;
		tick(60);
		chk(amp, 12'hFFF);
		i_dukc_host.wr(6'h21, 8'h0A);
		i_dukc_host.wr(6'h22, 8'hBC);
		i_dukc_host.wr(6'h20, 8'h20);
		pulse();
		chk(amp, 12'hABC);
		i_dukc_host.wr(6'h20, 8'h00);
		pulse();
		chk({amp, cout}, {12'hFFF, cos});
		i_dukc_host.wr(6'h3F, 8'h5A);
		i_dukc_host.rd(6'h3F, r);
		chk(r, 8'h5A);
		chk(oe, 1'b1);
		tick(4);
		chk(oe, 1'b0);
		$display("shape and readback test done");
		finish_test();
	end
endmodule
